// >>> verification/ufc_core_checker.sv
// ufc_core_checker.sv: concurrent checks on the ports of ufc_core.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
module ufc_core_checker #(
	parameter FIFO_DEPTH = 16
) (
	input wire       ref_clk_in,
	input wire       rst_n_in,
	input wire       rx_char_ready_out,
	input wire [5:0] rx_count_out,
	input wire [7:0] rhr_data_out,
	input wire       rhr_valid_out,
	input wire       rhr_rd_in,
	input wire       tx_char_valid_out,
	input wire       tx_char_ready_in,
	input wire [5:0] enhanced_feature_reg_in,
	input wire [7:0] interrupt_enable_reg_in,
	input wire [5:0] interrupt_status_reg_out,
	input wire       irq_out,
	input wire       tx_paused_out,
	input wire       rx_timeout_out,
	input wire       oversample_clock_out,
	input wire       prescale_sel_in,
	input wire [7:0] divisor_low_byte_in,
	input wire [7:0] divisor_high_byte_in
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Divisor of one, with or without the extra divide by four
	wire div1_w = ({divisor_high_byte_in, divisor_low_byte_in} == 16'h0001);
	wire fast_w = div1_w && !prescale_sel_in;
	wire pre4_w = div1_w && prescale_sel_in;
	a_irq_follows_status: assert property (irq_out == !interrupt_status_reg_out[0])
		else $error("irq disagrees with status");
	a_pause_blocks_tx: assert property (tx_paused_out && enhanced_feature_reg_in[3:2] == 2'h0 |-> !(tx_char_valid_out && tx_char_ready_in))
		else $error("char handed off while paused");
	a_timeout_needs_data: assert property (rx_timeout_out |-> rx_count_out != 6'h00)
		else $error("time-out with empty fifo");
	a_read_clears_to: assert property (rx_timeout_out && rhr_rd_in |=> !rx_timeout_out)
		else $error("time-out survived a read");
	a_to_status_code: assert property ((rx_timeout_out && interrupt_enable_reg_in[0]) [*2] |-> interrupt_status_reg_out == 6'h0c)
		else $error("time-out not reported");
	a_fast_tick_high: assert property (oversample_clock_out && fast_w ##1 fast_w |-> oversample_clock_out)
		else $error("tick dropped at divisor one");
	a_prescale_gap_four: assert property (pre4_w [*8] ##0 oversample_clock_out ##1 (pre4_w && !oversample_clock_out) [*3] ##1 pre4_w |-> oversample_clock_out)
		else $error("prescaled tick gap not four");
	a_full_refuses_rx: assert property (rx_count_out == FIFO_DEPTH + 1 |-> !rx_char_ready_out)
		else $error("full fifo still ready");
	a_rhr_holds_data: assert property (rhr_valid_out && !rhr_rd_in |=> rhr_valid_out && $stable(rhr_data_out))
		else $error("head changed without a read");
	// Main scenarios seen at least once
	c_pause: cover property ($rose(tx_paused_out));
	c_timeout: cover property ($rose(rx_timeout_out));
	c_full: cover property (rx_count_out == FIFO_DEPTH + 1);
endmodule
bind ufc_core ufc_core_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.ref_clk_in, .rst_n_in, .rx_char_ready_out, .rx_count_out,
	.rhr_data_out, .rhr_valid_out, .rhr_rd_in, .tx_char_valid_out,
	.tx_char_ready_in, .enhanced_feature_reg_in, .interrupt_enable_reg_in,
	.interrupt_status_reg_out, .irq_out, .tx_paused_out, .rx_timeout_out,
	.oversample_clock_out, .prescale_sel_in, .divisor_low_byte_in,
	.divisor_high_byte_in
);

// >>> verification/ufc_core_test.sv
// ufc_core_test.sv: self-checking bench for ufc_core.
// Assumes the bound checker and the partner model as transmit shifter.
`timescale 1ns/100ps
module ufc_core_test;
	logic       ref_clk_in = 1'b0, rst_n_in = 1'b0;      // Clock, reset
	logic [7:0] rx_char_in = 8'h00, thr_data_in = 8'h00; // Data inputs
	logic [7:0] char_data_in = 8'h00, busy_len = 8'h02;  // Char, line time
	logic [7:0] interrupt_enable_reg_in = 8'h00;         // Enables
	logic [7:0] divisor_low_byte_in = 8'h01, divisor_high_byte_in = 8'h00;
	logic [5:0] enhanced_feature_reg_in = 6'h00;         // Flow modes
	logic [1:0] word_length_in = 2'h3, rx_trigger_sel_in = 2'h0;
	logic [1:0] char_sel_in = 2'h0;                      // Char slot
	logic       rx_char_valid_in = 1'b0, rx_stop_center_in = 1'b0;
	logic       rhr_rd_in = 1'b0, thr_wr_in = 1'b0, prescale_sel_in = 1'b0;
	logic       char_wr_in = 1'b0, isr_rd_in = 1'b0, modem_status_rd_in = 1'b0;
	logic       rts_change_in = 1'b0, cts_change_in = 1'b0;
	wire  [7:0] rhr_data_out, tx_char_out, sent;         // Outputs
	wire  [5:0] interrupt_status_reg_out, rx_count_out;
	wire        rx_char_ready_out, rhr_valid_out, thr_ready_out, irq_out;
	wire        tx_char_valid_out, tx_char_ready_in, tx_paused_out;
	wire        rx_timeout_out, oversample_clock_out;
	int         num_errors = 0, compares = 0, i, n;      // Bookkeeping
	logic [7:0] k;                                       // Sent count mark
	ufc_core DUT (.ref_clk_in, .rst_n_in, .rx_char_in, .rx_char_valid_in,
		.rx_char_ready_out, .rx_stop_center_in, .rhr_data_out, .rhr_valid_out,
		.rhr_rd_in, .thr_data_in, .thr_wr_in, .thr_ready_out, .tx_char_out,
		.tx_char_valid_out, .tx_char_ready_in, .enhanced_feature_reg_in,
		.interrupt_enable_reg_in, .word_length_in, .rx_trigger_sel_in,
		.prescale_sel_in, .divisor_low_byte_in, .divisor_high_byte_in,
		.char_wr_in, .char_sel_in, .char_data_in, .isr_rd_in, .rts_change_in,
		.cts_change_in, .modem_status_rd_in, .interrupt_status_reg_out,
		.irq_out, .tx_paused_out, .rx_timeout_out, .oversample_clock_out,
		.rx_count_out);
	ufc_tx_partner TX (.clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.char_in(tx_char_out), .valid_in(tx_char_valid_out),
		.busy_len_in(busy_len), .ready_out(tx_char_ready_in),
		.sent_cnt_out(sent));
	// Free-running 100 MHz clock
	always #5 ref_clk_in = ~ref_clk_in;
	// Advance c edges, landing just after the edge
	task step(input int c);
		repeat (c) @(posedge ref_clk_in);
		#1;
	endtask
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			num_errors++;
		end
	endtask
	task stat(input logic [7:0] exp);
		check("status", {2'h0, interrupt_status_reg_out}, exp);
	endtask
	// One-cycle strobe: 0 read, 1 status, 2 modem, 3 cts, 4 rts, 5 stop
	task pulse(input int s);
		{rhr_rd_in, isr_rd_in, modem_status_rd_in, cts_change_in,
			rts_change_in, rx_stop_center_in} = 6'h20 >> s;
		step(1);
		{rhr_rd_in, isr_rd_in, modem_status_rd_in, cts_change_in,
			rts_change_in, rx_stop_center_in} = 6'h00;
		step(2);
	endtask
	// Offer a char, hold it until taken, then let an edge pass
	task rx_send(input logic [7:0] c);
		rx_char_in = c;
		rx_char_valid_in = 1'b1;
		n = 0;
		while (rx_char_ready_out !== 1'b1 && n < 50)
		begin
			step(1);
			n++;
		end
		if (n == 50)
			num_errors++;
		step(1);
		rx_char_valid_in = 1'b0;
		step(1);
	endtask
	task rd_chk(input logic [7:0] exp);
		check("rhr_data", rhr_data_out, exp);
		pulse(0);
		step(1);
	endtask
	task wchar(input logic [1:0] s, input logic [7:0] d);
		char_sel_in = s;
		char_data_in = d;
		char_wr_in = 1'b1;
		step(1);
		char_wr_in = 1'b0;
		step(1);
	endtask
	task wrap_up;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the expected run of under two thousand cycles
	initial
	begin
		#100000;
		num_errors++;
		wrap_up;
	end
	// Main sequence
	initial
	begin
		step(16);
		rst_n_in = 1'b1;
		step(2);
		pulse(4);
		stat(8'h01);
		pulse(2);
		interrupt_enable_reg_in = 8'h82;
		step(3);
		stat(8'h02);
		pulse(3);
		stat(8'h02);
		pulse(1);
		stat(8'h20);
		pulse(2);
		stat(8'h01);
		// Special detection against the cleared second pause char
		interrupt_enable_reg_in = 8'h20;
		enhanced_feature_reg_in = 6'h20;
		rx_send(8'h00);
		step(2);
		check("count", {2'h0, rx_count_out}, 8'h01);
		stat(8'h10);
		pulse(1);
		rd_chk(8'h00);
		// Single-char pause and resume on the first chars
		wchar(2'h0, 8'h11);
		wchar(2'h1, 8'h12);
		wchar(2'h2, 8'h13);
		wchar(2'h3, 8'h14);
		enhanced_feature_reg_in = 6'h02;
		rx_send(8'h13);
		check("paused", {7'h0, tx_paused_out}, 8'h01);
		check("count", {2'h0, rx_count_out}, 8'h00);
		stat(8'h10);
		k = sent;
		thr_data_in = 8'h41;
		thr_wr_in = 1'b1;
		step(1);
		thr_wr_in = 1'b0;
		step(30);
		check("sent", sent, k);
		check("thr_ready", {7'h0, thr_ready_out}, 8'h00);
		rx_send(8'h11);
		check("paused", {7'h0, tx_paused_out}, 8'h00);
		stat(8'h01);
		step(20);
		check("tx_char", TX.log_r[k[4:0]], 8'h41);
		// Double chars: a lone first half is plain data
		enhanced_feature_reg_in = 6'h03;
		rx_send(8'h13);
		rx_send(8'h55);
		step(2);
		check("count", {2'h0, rx_count_out}, 8'h02);
		rx_send(8'h13);
		rx_send(8'h14);
		check("paused", {7'h0, tx_paused_out}, 8'h01);
		rx_send(8'h11);
		rx_send(8'h12);
		check("paused", {7'h0, tx_paused_out}, 8'h00);
		check("count", {2'h0, rx_count_out}, 8'h02);
		rd_chk(8'h13);
		rd_chk(8'h55);
		// Five-bit words ignore upper bits; second-char mode resumes
		word_length_in = 2'h0;
		enhanced_feature_reg_in = 6'h02;
		rx_send(8'hf3);
		check("paused", {7'h0, tx_paused_out}, 8'h01);
		enhanced_feature_reg_in = 6'h01;
		rx_send(8'hf2);
		check("paused", {7'h0, tx_paused_out}, 8'h00);
		word_length_in = 2'h3;
		// Automatic pause at fill 16 and resume at fill 0, slow shifter
		interrupt_enable_reg_in = 8'h01;
		enhanced_feature_reg_in = 6'h0c;
		busy_len = 8'd12;
		k = sent;
		for (i = 0; i < 17; i++)
		begin
			rx_send(8'h20 + i[7:0]);
			if (i == 7)
				stat(8'h04);
		end
		step(60);
		check("tx_char", TX.log_r[k[4:0]], 8'h13);
		check("tx_char", TX.log_r[k[4:0] + 5'h1], 8'h14);
		check("ready", {7'h0, rx_char_ready_out}, 8'h00);
		for (i = 0; i < 17; i++)
			rd_chk(8'h20 + i[7:0]);
		step(60);
		check("tx_char", TX.log_r[k[4:0] + 5'h2], 8'h11);
		check("tx_char", TX.log_r[k[4:0] + 5'h3], 8'h12);
		check("sent", sent, k + 8'h04);
		// Time-out at divisor one: 640 ticks, restarted by stop centre
		enhanced_feature_reg_in = 6'h00;
		{divisor_high_byte_in, divisor_low_byte_in} = 16'h0001;
		rx_send(8'h5a);
		step(400);
		pulse(5);
		step(400);
		check("timeout", {7'h0, rx_timeout_out}, 8'h00);
		n = 0;
		while (rx_timeout_out !== 1'b1 && n < 400)
		begin
			step(1);
			n++;
		end
		check("timeout", {7'h0, rx_timeout_out}, 8'h01);
		step(1);
		stat(8'h0c);
		rd_chk(8'h5a);
		check("timeout", {7'h0, rx_timeout_out}, 8'h00);
		stat(8'h01);
		// Tick rate over 120 cycles: divisor 3, prescale with 1 and 2
		for (i = 0; i < 3; i++)
		begin
			prescale_sel_in = (i != 0);
			divisor_low_byte_in = (i == 0) ? 8'h03 : i[7:0];
			step(20);
			n = 0;
			repeat (120)
			begin
				n += oversample_clock_out;
				step(1);
			end
			check("ticks", n[7:0], (i == 0) ? 8'd40 : 8'd120 / (8'd4 * i[7:0]));
		end
		wrap_up;
	end
endmodule

// >>> verification/ufc_tx_partner.sv
// ufc_tx_partner.sv: transmit shifter and remote end of the link.
// Assumes the core's clock and reset; one char at a time, then busy.
`timescale 1ns/100ps
module ufc_tx_partner (
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire  [7:0] char_in,
	input  wire        valid_in,
	input  wire  [7:0] busy_len_in,
	output logic       ready_out,
	output logic [7:0] sent_cnt_out
);
	logic [7:0] busy_r;        // Cycles left of the char on the line
	logic [7:0] log_r [0:31];  // Last 32 chars sent, in order
	// Ready only while idle, so a char is never cut short
	assign ready_out = (busy_r == 8'h00);
	// Take a char at the handoff edge, then shift it out slowly
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			busy_r       <= 8'h00;
			sent_cnt_out <= 8'h00;
		end
		else if (valid_in && ready_out)
		begin
			busy_r                    <= busy_len_in;
			log_r[sent_cnt_out[4:0]]  <= char_in;
			sent_cnt_out              <= sent_cnt_out + 8'h01;
		end
		else if (busy_r != 8'h00)
			busy_r <= busy_r - 8'h01;
	end
endmodule

// >>> verilog/ufc_core.v
// ufc_core.v: software flow control, receive FIFO, time-out,
// interrupt status and baud generator of the UART.
// Assumes a receiver and a transmit shifter on the same clock,
// control bits driven as plain ports by the host interface.
`timescale 1ns/100ps
`include "ufc_regs.vh"
module ufc_core #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire       ref_clk_in,
	input  wire       rst_n_in,
	input  wire [7:0] rx_char_in,
	input  wire       rx_char_valid_in,
	output wire       rx_char_ready_out,
	input  wire       rx_stop_center_in,
	output wire [7:0] rhr_data_out,
	output wire       rhr_valid_out,
	input  wire       rhr_rd_in,
	input  wire [7:0] thr_data_in,
	input  wire       thr_wr_in,
	output wire       thr_ready_out,
	output wire [7:0] tx_char_out,
	output wire       tx_char_valid_out,
	input  wire       tx_char_ready_in,
	input  wire [5:0] enhanced_feature_reg_in,
	input  wire [7:0] interrupt_enable_reg_in,
	input  wire [1:0] word_length_in,
	input  wire [1:0] rx_trigger_sel_in,
	input  wire       prescale_sel_in,
	input  wire [7:0] divisor_low_byte_in,
	input  wire [7:0] divisor_high_byte_in,
	input  wire       char_wr_in,
	input  wire [1:0] char_sel_in,
	input  wire [7:0] char_data_in,
	input  wire       isr_rd_in,
	input  wire       rts_change_in,
	input  wire       cts_change_in,
	input  wire       modem_status_rd_in,
	output wire [5:0] interrupt_status_reg_out,
	output wire       irq_out,
	output wire       tx_paused_out,
	output wire       rx_timeout_out,
	output wire       oversample_clock_out,
	output wire [5:0] rx_count_out
);
	localparam [10:0] TO_LAST =
		`UFC_TO_CHARS * `UFC_CHAR_BITS * `UFC_OS_PER_BIT - 1;
	reg [7:0]  resume_char_first_r;  // Flow characters
	reg [7:0]  resume_char_second_r;
	reg [7:0]  pause_char_first_r;
	reg [7:0]  pause_char_second_r;
	reg [7:0]  wl_mask;              // Significant character bits
	wire [1:0] rx_mode;
	wire [1:0] tx_mode;
	wire       special;
	wire       m_pf, m_ps, m_rf, m_rs; // Incoming char matches
	wire       acc;                  // Receive char taken
	wire       fifo_wr_ready;
	wire [FIFO_AW:0] fifo_cnt;
	wire [5:0] cnt;                  // Fill incl. read stage
	reg        push_v;               // Write to receive FIFO
	reg [7:0]  push_d;
	reg        act_pause, act_resume, special_hit;
	reg        pend_v_r, pend_v_nxt;       // Held char (double)
	reg        pend_plain_r, pend_plain_nxt; // Held char is data
	reg        pend_pause_r, pend_pause_nxt; // Held first is pause
	reg [7:0]  pend_d_r, pend_d_nxt;
	reg        tx_paused_r;          // Transmit suspended
	reg        pause_flag_r;         // Pause or special seen
	reg [5:0]  trig, pthr, rthr;     // Levels from trigger select
	reg        sent_pause_r;         // Pause chars sent
	reg        fc_busy_r;            // Flow char sequence running
	reg        fc_pause_r;           // Sequence kind
	reg        fc_idx_r;             // 0 first char, 1 second
	wire [7:0] fc_char;
	wire       host_go, tx_fire, fc_fire, host_fire;
	reg        thr_full_r;           // Transmit holding occupied
	reg [7:0]  thr_r;
	reg        thr_int_r;            // Holding-empty interrupt
	reg        ier_thr_d_r;          // Previous TRANSMIT_HOLDING_REG enable
	reg        rts_flag_r, cts_flag_r;
	reg [10:0] to_cnt_r;             // Idle oversample ticks
	reg        to_r;                 // Time-out pending
	reg [5:0]  isr_nxt;
	reg [5:0]  isr_r;
	reg [1:0]  pre_cnt_r;            // Divide-by-4 prescaler
	reg [15:0] div_cnt_r;            // Baud divisor counter
	reg        os_tick_r;            // One tick per 16x period
	wire       pre_tick;
	wire [15:0] divisor;

	assign rx_mode = enhanced_feature_reg_in[`UFC_EFR_RXM_LO+1:
		`UFC_EFR_RXM_LO];
	assign tx_mode = enhanced_feature_reg_in[`UFC_EFR_TXM_LO+1:
		`UFC_EFR_TXM_LO];
	assign special = enhanced_feature_reg_in[`UFC_EFR_SPECIAL];

	// Flow character registers, host written at any time
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			resume_char_first_r  <= `UFC_CHAR_RST;
			resume_char_second_r <= `UFC_CHAR_RST;
			pause_char_first_r   <= `UFC_CHAR_RST;
			pause_char_second_r  <= `UFC_CHAR_RST;
		end
		else if (char_wr_in)
		begin
			case (char_sel_in)
				2'h0: resume_char_first_r  <= char_data_in;
				2'h1: resume_char_second_r <= char_data_in;
				2'h2: pause_char_first_r   <= char_data_in;
				default: pause_char_second_r <= char_data_in;
			endcase
		end
	end

	// Only the programmed word length takes part in a match
	always @*
	begin
		case (word_length_in)
			2'h0: wl_mask = 8'h1f;
			2'h1: wl_mask = 8'h3f;
			2'h2: wl_mask = 8'h7f;
			default: wl_mask = 8'hff;
		endcase
	end
	assign m_pf = ((rx_char_in ^ pause_char_first_r) & wl_mask) == 8'h00;
	assign m_ps = ((rx_char_in ^ pause_char_second_r) & wl_mask) == 8'h00;
	assign m_rf = ((rx_char_in ^ resume_char_first_r) & wl_mask) == 8'h00;
	assign m_rs = ((rx_char_in ^ resume_char_second_r) & wl_mask) == 8'h00;

	// A data char held for one cycle stalls the receiver
	assign rx_char_ready_out = fifo_wr_ready & ~(pend_v_r & pend_plain_r);
	assign acc = rx_char_valid_in & rx_char_ready_out;

	// Receive classification: store, consume or hold
	always @*
	begin
		push_v = 1'b0;
		push_d = rx_char_in;
		act_pause = 1'b0;
		act_resume = 1'b0;
		special_hit = 1'b0;
		pend_v_nxt = pend_v_r;
		pend_plain_nxt = pend_plain_r;
		pend_pause_nxt = pend_pause_r;
		pend_d_nxt = pend_d_r;
		if (pend_v_r & (pend_plain_r | rx_mode != `UFC_FCM_DOUBLE))
		begin
			// Release a held char once the FIFO has room
			push_v = fifo_wr_ready;
			push_d = pend_d_r;
			pend_v_nxt = ~fifo_wr_ready;
		end
		else if (acc)
		begin
			case (rx_mode)
				`UFC_FCM_FIRST, `UFC_FCM_SECOND:
				begin
					// Single char compare, matches are dropped
					if (rx_mode == `UFC_FCM_FIRST ? m_pf : m_ps)
						act_pause = 1'b1;
					else if (rx_mode == `UFC_FCM_FIRST ? m_rf : m_rs)
						act_resume = 1'b1;
					else
						push_v = 1'b1;
				end
				`UFC_FCM_DOUBLE:
				begin
					if (pend_v_r & (pend_pause_r ? m_ps : m_rs))
					begin
						// Both halves seen, neither stored
						act_pause = pend_pause_r;
						act_resume = ~pend_pause_r;
						pend_v_nxt = 1'b0;
					end
					else if (pend_v_r)
					begin
						// Held first half was data after all
						push_v = 1'b1;
						push_d = pend_d_r;
						pend_d_nxt = rx_char_in;
						pend_plain_nxt = ~(m_pf | m_rf);
						pend_pause_nxt = m_pf;
					end
					else if (m_pf | m_rf)
					begin
						pend_v_nxt = 1'b1;
						pend_plain_nxt = 1'b0;
						pend_pause_nxt = m_pf;
						pend_d_nxt = rx_char_in;
					end
					else
						push_v = 1'b1;
				end
				default:
				begin
					// Special mode keeps the char and flags it
					push_v = 1'b1;
					special_hit = special & m_ps;
				end
			endcase
		end
	end

	// Held char and pause state
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pend_v_r <= 1'b0;
			pend_plain_r <= 1'b0;
			pend_pause_r <= 1'b0;
			pend_d_r <= 8'h00;
			tx_paused_r <= 1'b0;
			pause_flag_r <= 1'b0;
		end
		else
		begin
			pend_v_r <= pend_v_nxt;
			pend_plain_r <= pend_plain_nxt;
			pend_pause_r <= pend_pause_nxt;
			pend_d_r <= pend_d_nxt;
			if (act_pause)
				tx_paused_r <= 1'b1;
			else if (act_resume)
				tx_paused_r <= 1'b0;
			// Set wins over a clear in the same cycle
			if ((act_pause & interrupt_enable_reg_in[`UFC_IER_PAUSE])
				| special_hit)
				pause_flag_r <= 1'b1;
			else if (act_resume |
				(isr_rd_in & isr_r == `UFC_ISR_PAUSE))
				pause_flag_r <= 1'b0;
		end
	end

	// Receive FIFO towards the host
	ufc_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_rx_fifo (
		.clk_in       (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.wr_valid_in  (push_v),
		.wr_data_in   (push_d),
		.wr_ready_out (fifo_wr_ready),
		.rd_valid_out (rhr_valid_out),
		.rd_data_out  (rhr_data_out),
		.rd_ready_in  (rhr_rd_in),
		.count_out    (fifo_cnt)
	);
	// Depth is limited to 32 by this zero extension
	assign cnt = {{(5-FIFO_AW){1'b0}}, fifo_cnt};
	assign rx_count_out = cnt;

	// Trigger select sets interrupt, pause and resume levels
	always @*
	begin
		case (rx_trigger_sel_in)
			2'h0: begin trig = `UFC_TRIG0; pthr = `UFC_PTHR0;
				rthr = `UFC_RTHR0; end
			2'h1: begin trig = `UFC_TRIG1; pthr = `UFC_PTHR1;
				rthr = `UFC_RTHR1; end
			2'h2: begin trig = `UFC_TRIG2; pthr = `UFC_PTHR2;
				rthr = `UFC_RTHR2; end
			default: begin trig = `UFC_TRIG3; pthr = `UFC_PTHR3;
				rthr = `UFC_RTHR3; end
		endcase
	end

	// Outgoing flow chars beat host data at each handoff
	assign fc_char = fc_idx_r ?
		(fc_pause_r ? pause_char_second_r : resume_char_second_r) :
		(fc_pause_r ? pause_char_first_r : resume_char_first_r);
	assign host_go = thr_full_r & ~tx_paused_r;
	assign tx_char_valid_out = fc_busy_r | host_go;
	assign tx_char_out = fc_busy_r ? fc_char : thr_r;
	assign tx_fire = tx_char_valid_out & tx_char_ready_in;
	assign fc_fire = tx_fire & fc_busy_r;
	assign host_fire = tx_fire & ~fc_busy_r;
	assign thr_ready_out = ~thr_full_r;
	assign tx_paused_out = tx_paused_r;

	// Automatic pause and resume sequences
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sent_pause_r <= 1'b0;
			fc_busy_r <= 1'b0;
			fc_pause_r <= 1'b0;
			fc_idx_r <= 1'b0;
		end
		else if (tx_mode == `UFC_FCM_OFF)
		begin
			// Sequence in flight still completes whole chars
			sent_pause_r <= 1'b0;
			if (fc_fire)
				fc_busy_r <= 1'b0;
		end
		else if (fc_busy_r)
		begin
			if (fc_fire & tx_mode == `UFC_FCM_DOUBLE & ~fc_idx_r)
				fc_idx_r <= 1'b1;
			else if (fc_fire)
			begin
				fc_busy_r <= 1'b0;
				sent_pause_r <= fc_pause_r;
			end
		end
		else if ((~sent_pause_r & cnt >= pthr) |
			(sent_pause_r & cnt <= rthr))
		begin
			fc_busy_r <= 1'b1;
			fc_pause_r <= ~sent_pause_r;
			fc_idx_r <= (tx_mode == `UFC_FCM_SECOND);
		end
	end

	// Transmit holding register and its empty interrupt
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			thr_full_r <= 1'b0;
			thr_r <= 8'h00;
			thr_int_r <= 1'b0;
			ier_thr_d_r <= 1'b0;
		end
		else
		begin
			ier_thr_d_r <= interrupt_enable_reg_in[`UFC_IER_THR];
			if (thr_wr_in & ~thr_full_r)
			begin
				thr_full_r <= 1'b1;
				thr_r <= thr_data_in;
			end
			else if (host_fire)
				thr_full_r <= 1'b0;
			// Enable edge with empty holding register raises it
			if (interrupt_enable_reg_in[`UFC_IER_THR] &
				((~ier_thr_d_r & ~thr_full_r) | host_fire))
				thr_int_r <= 1'b1;
			else if (thr_wr_in |
				(isr_rd_in & isr_r == `UFC_ISR_THR))
				thr_int_r <= 1'b0;
		end
	end

	// Modem change flags, each behind its own enable
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rts_flag_r <= 1'b0;
			cts_flag_r <= 1'b0;
		end
		else
		begin
			if (rts_change_in & interrupt_enable_reg_in[`UFC_IER_RTS])
				rts_flag_r <= 1'b1;
			else if (modem_status_rd_in)
				rts_flag_r <= 1'b0;
			if (cts_change_in & interrupt_enable_reg_in[`UFC_IER_CTS])
				cts_flag_r <= 1'b1;
			else if (modem_status_rd_in)
				cts_flag_r <= 1'b0;
		end
	end

	// Receive time-out counts oversample ticks while data waits
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			to_cnt_r <= 11'h000;
			to_r <= 1'b0;
		end
		else if (rx_stop_center_in | rhr_rd_in | cnt == 6'h00)
		begin
			to_cnt_r <= 11'h000;
			to_r <= 1'b0;
		end
		else if (os_tick_r & ~to_r)
		begin
			to_cnt_r <= to_cnt_r + 11'h001;
			if (to_cnt_r == TO_LAST)
				to_r <= 1'b1;
		end
	end
	assign rx_timeout_out = to_r;

	// Highest pending source only; modem changes come last
	always @*
	begin
		if (to_r & interrupt_enable_reg_in[`UFC_IER_RXD])
			isr_nxt = `UFC_ISR_RXTO;
		else if (cnt >= trig & interrupt_enable_reg_in[`UFC_IER_RXD])
			isr_nxt = `UFC_ISR_RXD;
		else if (thr_int_r)
			isr_nxt = `UFC_ISR_THR;
		else if (pause_flag_r & interrupt_enable_reg_in[`UFC_IER_PAUSE])
			isr_nxt = `UFC_ISR_PAUSE;
		else if (rts_flag_r | cts_flag_r)
			isr_nxt = `UFC_ISR_MODEM;
		else
			isr_nxt = `UFC_ISR_NONE;
	end
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			isr_r <= `UFC_ISR_NONE;
		else
			isr_r <= isr_nxt;
	end
	assign interrupt_status_reg_out = isr_r;
	assign irq_out = ~isr_r[0];

	// Baud generator: optional divide by 4, then the divisor
	assign divisor = {divisor_high_byte_in, divisor_low_byte_in};
	assign pre_tick = ~prescale_sel_in | pre_cnt_r == `UFC_PRE_LAST;
	always @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pre_cnt_r <= 2'h0;
			div_cnt_r <= 16'h0000;
			os_tick_r <= 1'b0;
		end
		else
		begin
			pre_cnt_r <= prescale_sel_in ? pre_cnt_r + 2'h1 : 2'h0;
			if (pre_tick & div_cnt_r <= 16'h0001)
			begin
				// Divisor zero is outside range and stops ticks
				div_cnt_r <= divisor;
				os_tick_r <= divisor != 16'h0000;
			end
			else
			begin
				if (pre_tick)
					div_cnt_r <= div_cnt_r - 16'h0001;
				os_tick_r <= 1'b0;
			end
		end
	end
	assign oversample_clock_out = os_tick_r;
endmodule

// >>> verilog/ufc_fifo.v
// ufc_fifo.v: receive FIFO, memory plus registered read stage.
// Assumes one clock; DEPTH a power of two equal to 2**AW.
`timescale 1ns/100ps
module ufc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             wr_valid_in,
	input  wire [WIDTH-1:0] wr_data_in,
	output wire             wr_ready_out,
	output wire             rd_valid_out,
	output wire [WIDTH-1:0] rd_data_out,
	input  wire             rd_ready_in,
	output wire [AW:0]      count_out
);
	localparam [AW:0] FULL = DEPTH;
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage, no reset needed
	reg [AW-1:0]    wp_r;            // Write pointer
	reg [AW-1:0]    rp_r;            // Read pointer
	reg [AW:0]      used_r;          // Words held in memory
	reg             out_v_r;         // Read stage holds a word
	reg [WIDTH-1:0] out_d_r;         // Read stage data
	wire            wr_fire;
	wire            load;
	assign wr_fire      = wr_valid_in & wr_ready_out;
	// Refill the read stage when empty or being drained
	assign load         = (used_r != {(AW+1){1'b0}}) &
		(~out_v_r | rd_ready_in);
	assign wr_ready_out = (used_r != FULL);
	assign rd_valid_out = out_v_r;
	assign rd_data_out  = out_d_r;
	// Read stage counts too, so count may reach DEPTH+1
	assign count_out    = used_r + {{AW{1'b0}}, out_v_r};
	// Memory write port
	always @(posedge clk_in)
	begin
		if (wr_fire)
			mem[wp_r] <= wr_data_in;
	end
	// Pointers, occupancy and read stage
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wp_r    <= {AW{1'b0}};
			rp_r    <= {AW{1'b0}};
			used_r  <= {(AW+1){1'b0}};
			out_v_r <= 1'b0;
			out_d_r <= {WIDTH{1'b0}};
		end
		else
		begin
			if (wr_fire)
				wp_r <= wp_r + 1'b1;
			if (load)
			begin
				rp_r    <= rp_r + 1'b1;
				out_d_r <= mem[rp_r];
				out_v_r <= 1'b1;
			end
			else if (rd_ready_in)
				out_v_r <= 1'b0;
			used_r <= used_r + {{AW{1'b0}}, wr_fire} -
				{{AW{1'b0}}, load};
		end
	end
endmodule

// >>> verilog/ufc_regs.vh
// ufc_regs.vh: field positions, encodings, reset values and counts
// for the flow-control and baud-generator block.
// Assumes inclusion by ufc_core.v only; definitions, no logic.
`ifndef UFC_REGS_VH
`define UFC_REGS_VH
// Enhanced feature field positions
`define UFC_EFR_RXM_LO   0
`define UFC_EFR_TXM_LO   2
`define UFC_EFR_SPECIAL  5
// Interrupt enable bit positions
`define UFC_IER_RXD      0
`define UFC_IER_THR      1
`define UFC_IER_PAUSE    5
`define UFC_IER_RTS      6
`define UFC_IER_CTS      7
// Flow mode encodings (rx compare and tx insert)
`define UFC_FCM_OFF      2'h0
`define UFC_FCM_SECOND   2'h1
`define UFC_FCM_FIRST    2'h2
`define UFC_FCM_DOUBLE   2'h3
// Reset value of the flow character registers
`define UFC_CHAR_RST     8'h00
// Data-ready trigger, pause and resume fill levels
`define UFC_TRIG0        6'h08
`define UFC_TRIG1        6'h10
`define UFC_TRIG2        6'h18
`define UFC_TRIG3        6'h1c
`define UFC_PTHR0        6'h10
`define UFC_PTHR1        6'h18
`define UFC_PTHR2        6'h1c
`define UFC_PTHR3        6'h1c
`define UFC_RTHR0        6'h00
`define UFC_RTHR1        6'h07
`define UFC_RTHR2        6'h0f
`define UFC_RTHR3        6'h17
// Interrupt status codes, bit 0 high means nothing pending
`define UFC_ISR_NONE     6'h01
`define UFC_ISR_RXTO     6'h0c
`define UFC_ISR_RXD      6'h04
`define UFC_ISR_THR      6'h02
`define UFC_ISR_PAUSE    6'h10
`define UFC_ISR_MODEM    6'h20
// Time-out length and oversampling
`define UFC_TO_CHARS     4
`define UFC_CHAR_BITS    10
`define UFC_OS_PER_BIT   16
`define UFC_PRE_LAST     2'h3
`endif
